// ===== rtl/load_switch_and_misc_config_regs.sv
// Notes on behaviour
// - Mode 00 turns the switch off, mode 01 forces it on.
// - Mode 10 runs bypass, switch follows the converter four comparator.
// - Mode 11 runs bypass with the switch held closed.
// - Bypass plus overvoltage blocks forced PWM and clears mode to 00.
// - Reset loads mode high bit and low bit from the two enable pins.
// - Two-bit current limit code selects 100 mA, 500 mA, 750 mA, 2.5 A.
// - Bits 7-4 of the switch control register ignore writes, read zero.
// - Gating bit 1 runs the fast oscillator only on power or clock request.
// - Delay bit 0 delays a lowering select change 0.5 to 1 slow periods.
// - Immediate bit 1 applies converter four voltage writes without slew.
// - Clock output drive bit chooses push-pull at 0, open-drain at 1.
// - Version register is read-only: fuse version high, revision low.
// - Power-on reset restores every register, fuse fields from fuses.
`timescale 1ns/1ps
`default_nettype none
`include "lsw_regs.svh"

module load_switch_and_misc_config_regs
  import lsw_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire avs_req_t avs_req_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic switch_mode_pin_hi_i,
  input wire logic switch_mode_pin_lo_i,
  input wire logic power_request_pin_i,
  input wire logic clock_request_pin_i,
  input wire logic buck4_voltage_select_pin_i,
  input wire logic [1:0] fuse_current_limit_sel_i,
  input wire logic [3:0] fuse_misc_i,
  input wire logic [7:0] fuse_version_i,
  input wire logic device_on_i,
  input wire logic buck4_bypass_cmp_i,
  input wire logic buck4_overvoltage_i,
  output logic switch_on_o,
  output logic bypass_mode_o,
  output logic forced_pwm_block_o,
  output logic [1:0] current_limit_sel_o,
  output logic fast_osc_en_o,
  output logic buck4_select_eff_o,
  output logic immediate_change_o,
  output logic slow_clock_output_o,
  output logic slow_clock_output_oe_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int NPIN = 5;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_f;
  logic mode_pin_hi;
  logic mode_pin_lo;
  logic power_request_pin;
  logic clk_req;
  logic sel_pin;

  assign pin_raw = {buck4_voltage_select_pin_i, clock_request_pin_i,
                    power_request_pin_i, switch_mode_pin_lo_i,
                    switch_mode_pin_hi_i};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic f_r;
      always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
          f_r <= 1'b0;
        end else begin
          s1_r <= pin_raw[gi];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) begin
            f_r <= s3_r;
          end
        end
      end
      assign pin_f[gi] = f_r;
    end
  endgenerate

  assign mode_pin_hi = pin_f[0];
  assign mode_pin_lo = pin_f[1];
  assign power_request_pin = pin_f[2];
  assign clk_req = pin_f[3];
  assign sel_pin = pin_f[4];

  // ----------------------------------------------------------------
  // Strap and fuse load after reset release
  // ----------------------------------------------------------------
  logic [2:0] init_cnt_r;
  logic ready_r;
  logic load_now;

  assign load_now = !ready_r && (init_cnt_r == `LSW_INIT_CYCLES);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      init_cnt_r <= 3'h0;
      ready_r <= 1'b0;
    end else if (load_now) begin
      ready_r <= 1'b1;
    end else if (!ready_r) begin
      init_cnt_r <= init_cnt_r + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------
  logic ack_r;
  logic ack_nxt;
  logic req;
  logic [31:0] rdata_nxt;
  logic [31:0] readdata_r;
  logic wr_ls;
  logic wr_misc;

  function automatic logic hit(input logic [9:0] a, input logic [7:0] idx);
    hit = (a[9:2] == idx) && (a[1:0] == 2'h0);
  endfunction : hit

  assign req = avs_req_i.read || avs_req_i.write;
  assign ack_nxt = req && !ack_r && ready_r;
  assign avs_waitrequest_o = req && !ack_r;
  assign avs_readdata_o = readdata_r;
  assign wr_ls = ack_r && avs_req_i.write && avs_req_i.byteenable[0]
                 && hit(avs_req_i.address, `LSW_IDX_LOAD_SWITCH);
  assign wr_misc = ack_r && avs_req_i.write && avs_req_i.byteenable[0]
                   && hit(avs_req_i.address, `LSW_IDX_MISC_FUSE);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Switch control register
  // ----------------------------------------------------------------
  sw_mode_t mode_r;
  logic [1:0] current_limit_sel_r;
  logic bypass;
  logic ov_trip;
  logic pwm_block_r;

  assign bypass = (mode_r == MODE_BYP_AUTO) || (mode_r == MODE_BYP_HOLD);
  assign ov_trip = ready_r && bypass && buck4_overvoltage_i;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_r <= sw_mode_t'(`LSW_MODE_RST);
    end else if (load_now) begin
      mode_r <= sw_mode_t'({mode_pin_hi, mode_pin_lo});
    end else if (ov_trip) begin
      mode_r <= MODE_OFF;
    end else if (wr_ls) begin
      mode_r <= sw_mode_t'(avs_req_i.writedata[`LSW_MODE_HI:`LSW_MODE_LO]);
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pwm_block_r <= 1'b0;
    end else if (ov_trip) begin
      pwm_block_r <= 1'b1;
    end else if (wr_ls || load_now) begin
      pwm_block_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      current_limit_sel_r <= `LSW_CURRENT_LIMIT_SEL_RST;
    end else if (load_now) begin
      current_limit_sel_r <= fuse_current_limit_sel_i;
    end else if (wr_ls) begin
      current_limit_sel_r <= avs_req_i.writedata[`LSW_CURRENT_LIMIT_SEL_HI:`LSW_CURRENT_LIMIT_SEL_LO];
    end
  end

  always_comb begin
    case (mode_r)
      MODE_OFF: switch_on_o = 1'b0;
      MODE_ON: switch_on_o = 1'b1;
      MODE_BYP_AUTO: switch_on_o = buck4_bypass_cmp_i;
      default: switch_on_o = 1'b1;
    endcase
  end

  assign bypass_mode_o = bypass;
  assign forced_pwm_block_o = pwm_block_r;
  assign current_limit_sel_o = current_limit_sel_r;

  // ----------------------------------------------------------------
  // Fuse option register
  // ----------------------------------------------------------------
  misc_opts_t misc_r;
  logic [7:0] ver_r;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      misc_r <= misc_opts_t'(`LSW_MISC_RST);
    end else if (load_now) begin
      misc_r <= misc_opts_t'(fuse_misc_i);
    end else if (wr_misc) begin
      misc_r <= misc_opts_t'(avs_req_i.writedata[3:0]);
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ver_r <= `LSW_VER_RST;
    end else if (load_now) begin
      ver_r <= fuse_version_i;
    end
  end

  assign fast_osc_en_o = device_on_i && (!misc_r.osc_gate || power_request_pin
                         || clk_req);
  assign immediate_change_o = misc_r.immediate;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (hit(avs_req_i.address, `LSW_IDX_LOAD_SWITCH)) begin
      rdata_nxt = {28'h000_0000, mode_r, current_limit_sel_r};
    end else if (hit(avs_req_i.address, `LSW_IDX_MISC_FUSE)) begin
      rdata_nxt = {28'h000_0000, misc_r};
    end else if (hit(avs_req_i.address, `LSW_IDX_VERSION)) begin
      rdata_nxt = {24'h00_0000, ver_r};
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      readdata_r <= 32'h0000_0000;
    end else if (ack_nxt && avs_req_i.read) begin
      readdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Slow clock divider and output pin
  // ----------------------------------------------------------------
  logic [10:0] half_cnt_r;
  logic half_tick;
  logic slow_clk_r;

  assign half_tick = (half_cnt_r == 11'(`LSW_HALF_CNT - 1));

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      half_cnt_r <= 11'h000;
      slow_clk_r <= 1'b0;
    end else if (half_tick) begin
      half_cnt_r <= 11'h000;
      slow_clk_r <= !slow_clk_r;
    end else begin
      half_cnt_r <= half_cnt_r + 11'h001;
    end
  end

  assign slow_clock_output_o = misc_r.clk_od ? 1'b0 : slow_clk_r;
  assign slow_clock_output_oe_o = misc_r.clk_od ? !slow_clk_r : 1'b1;

  // ----------------------------------------------------------------
  // Select pin delay
  // ----------------------------------------------------------------
  sel_state_t sel_st_r;
  logic sel_eff_r;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sel_st_r <= SEL_IDLE;
      sel_eff_r <= 1'b0;
    end else begin
      case (sel_st_r)
        SEL_IDLE: begin
          if (sel_pin != sel_eff_r) begin
            // rise or no-delay applies at once
            if (sel_pin || misc_r.sel_dly_bypass) begin
              sel_eff_r <= sel_pin;
            end else begin
              sel_st_r <= SEL_WAIT1;
            end
          end
        end
        SEL_WAIT1: begin
          if (sel_pin) begin
            sel_st_r <= SEL_IDLE;
          end else if (half_tick) begin
            sel_st_r <= SEL_WAIT2;
          end
        end
        SEL_WAIT2: begin
          if (sel_pin) begin
            sel_st_r <= SEL_IDLE;
          end else if (half_tick) begin
            sel_eff_r <= 1'b0;
            sel_st_r <= SEL_IDLE;
          end
        end
        default: sel_st_r <= SEL_IDLE;
      endcase
    end
  end

  assign buck4_select_eff_o = sel_eff_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  a_mode_off: assert property (mode_r == MODE_OFF |-> !switch_on_o)
    else $error("switch on in off mode");
  a_mode_forced_on: assert property (
    mode_r == MODE_ON |-> switch_on_o)
    else $error("switch off in forced-on mode");
  a_bypass_follow: assert property (
    mode_r == MODE_BYP_AUTO |-> switch_on_o == buck4_bypass_cmp_i)
    else $error("bypass switch not following comparator");
  a_bypass_hold: assert property (
    mode_r == MODE_BYP_HOLD && !buck4_bypass_cmp_i |-> switch_on_o)
    else $error("held bypass switch opened");
  a_ov_clear: assert property (
    ready_r && bypass && buck4_overvoltage_i
    |=> mode_r == MODE_OFF && forced_pwm_block_o)
    else $error("overvoltage did not clear mode");
  a_strap_load: assert property (
    load_now |=> mode_r == sw_mode_t'($past({mode_pin_hi, mode_pin_lo})))
    else $error("mode not loaded from pins");
  a_current_limit_sel_write: assert property (
    wr_ls && !load_now
    |=> current_limit_sel_o == $past(avs_req_i.writedata[1:0]))
    else $error("current limit write lost");
  a_rsvd_zero: assert property (
    ack_r && avs_req_i.read
    && hit(avs_req_i.address, `LSW_IDX_LOAD_SWITCH)
    |-> avs_readdata_o[31:4] == 28'h000_0000)
    else $error("reserved bits read nonzero");
  a_osc_gated: assert property (
    misc_r.osc_gate && !power_request_pin && !clk_req |-> !fast_osc_en_o)
    else $error("oscillator running while gated");
  a_sel_nodelay: assert property (
    sel_st_r == SEL_IDLE && sel_eff_r && !sel_pin
    && misc_r.sel_dly_bypass |=> !buck4_select_eff_o)
    else $error("undelayed select change late");
  a_sel_delayed: assert property (
    sel_st_r == SEL_IDLE && sel_eff_r && !sel_pin
    && !misc_r.sel_dly_bypass |=> buck4_select_eff_o [*8])
    else $error("delayed select change too early");
  a_ver_ro: assert property (
    ready_r |=> $stable(ver_r))
    else $error("version register changed");
  a_od_drive: assert property (
    misc_r.clk_od |-> !slow_clock_output_o)
    else $error("open-drain clock drove high");

endmodule : load_switch_and_misc_config_regs
`default_nettype wire

// ===== rtl/lsw_pkg.sv
`default_nettype none

package lsw_pkg;

  typedef struct packed {
    logic [9:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avs_req_t;

  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_ON = 2'h1,
    MODE_BYP_AUTO = 2'h2,
    MODE_BYP_HOLD = 2'h3
  } sw_mode_t;

  typedef enum logic [1:0] {
    SEL_IDLE = 2'h0,
    SEL_WAIT1 = 2'h1,
    SEL_WAIT2 = 2'h3
  } sel_state_t;

  typedef struct packed {
    logic osc_gate;
    logic sel_dly_bypass;
    logic immediate;
    logic clk_od;
  } misc_opts_t;

endpackage : lsw_pkg
`default_nettype wire

// ===== rtl/lsw_regs.svh
`ifndef LSW_REGS_SVH
`define LSW_REGS_SVH

// ----------------------------------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------------------------------
`define LSW_IDX_LOAD_SWITCH 8'h62
`define LSW_IDX_MISC_FUSE 8'h63
`define LSW_IDX_VERSION 8'h64

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LSW_MODE_HI 3
`define LSW_MODE_LO 2
`define LSW_CURRENT_LIMIT_SEL_HI 1
`define LSW_CURRENT_LIMIT_SEL_LO 0
`define LSW_OSC_GATE_BIT 3
`define LSW_SEL_DLY_BIT 2
`define LSW_IMMEDIATE_BIT 1
`define LSW_CLK_OD_BIT 0

// ----------------------------------------------------------------
// Reset values before fuses and straps are loaded
// ----------------------------------------------------------------
`define LSW_MODE_RST 2'h0
`define LSW_CURRENT_LIMIT_SEL_RST 2'h0
`define LSW_MISC_RST 4'h0
`define LSW_VER_RST 8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LSW_CLK_HZ 125000000
`define LSW_SLOW_HZ 32768
`define LSW_HALF_CNT (`LSW_CLK_HZ / (2 * `LSW_SLOW_HZ))
`define LSW_SEL_DLY_HALVES 2
`define LSW_INIT_CYCLES 3'h5

`endif

// ===== tb/tb_load_switch_and_misc_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "lsw_regs.svh"

module tb_load_switch_and_misc_config_regs
  import lsw_pkg::*;
  ;
  // Arbitrary fuse version values
  localparam logic [7:0] VER_A = 8'h5C;
  localparam logic [7:0] VER_B = 8'h3C;
  localparam logic [9:0] A_CTL = {`LSW_IDX_LOAD_SWITCH, 2'b00};
  localparam logic [9:0] A_MSC = {`LSW_IDX_MISC_FUSE, 2'b00};
  localparam logic [9:0] A_VER = {`LSW_IDX_VERSION, 2'b00};
  localparam logic [9:0] A_BAD = 10'h194;

  typedef struct packed {
    logic [7:0] d;
    logic c;
    logic [7:0] r;
    logic sw;
    logic by;
  } row_t;

  logic clk = 1'b0;
  logic arst_n, wreq, pin_hi, pin_lo, pwr, ckr, sel, dev_on, cmp, ov;
  logic sw_on, byp, blk, osc, sel_eff, imm, sck, sck_oe;
  logic [1:0] f_current_limit_sel, current_limit_sel;
  logic [3:0] f_misc;
  logic [7:0] f_ver;
  logic [31:0] rdata, q;
  avs_req_t req;
  int n_fail, n_checks, n, o1, e0;
  row_t rows [5] = '{
    '{8'hF0, 1'b1, 8'h00, 1'b0, 1'b0},
    '{8'h05, 1'b0, 8'h05, 1'b1, 1'b0},
    '{8'h0A, 1'b1, 8'h0A, 1'b1, 1'b1},
    '{8'h0B, 1'b0, 8'h0B, 1'b0, 1'b1},
    '{8'hFE, 1'b0, 8'h0E, 1'b1, 1'b1}
  };

  always #4 clk = ~clk;

  load_switch_and_misc_config_regs load_switch_and_misc_config_regs_inst (
    .clk_i(clk), .arst_n_i(arst_n), .avs_req_i(req),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .switch_mode_pin_hi_i(pin_hi), .switch_mode_pin_lo_i(pin_lo),
    .power_request_pin_i(pwr), .clock_request_pin_i(ckr),
    .buck4_voltage_select_pin_i(sel), .fuse_current_limit_sel_i(f_current_limit_sel),
    .fuse_misc_i(f_misc), .fuse_version_i(f_ver), .device_on_i(dev_on),
    .buck4_bypass_cmp_i(cmp), .buck4_overvoltage_i(ov),
    .switch_on_o(sw_on), .bypass_mode_o(byp), .forced_pwm_block_o(blk),
    .current_limit_sel_o(current_limit_sel), .fast_osc_en_o(osc),
    .buck4_select_eff_o(sel_eff), .immediate_change_o(imm),
    .slow_clock_output_o(sck), .slow_clock_output_oe_o(sck_oe)
  );

  // ----------------------------------------------------------------
  // Compare and bus tasks
  // ----------------------------------------------------------------
  task automatic chk_reg(input string nm, input logic [7:0] e,
                         input logic [31:0] g);
    n_checks++;
    if (g !== {24'h0, e}) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : chk_reg

  task automatic chk_pin(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %b got %b", nm, e, g);
    end
  endtask : chk_pin

  task automatic bus(input logic wr, input logic [9:0] a,
                     input logic [7:0] d, input logic [3:0] be);
    req.address <= a;
    req.read <= ~wr;
    req.write <= wr;
    req.writedata <= {24'h0, d};
    req.byteenable <= be;
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    q = rdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask : wr_reg

  task automatic rd_chk(input string nm, input logic [9:0] a,
                        input logic [7:0] e);
    bus(1'b0, a, 8'h00, 4'hF);
    chk_reg(nm, e, q);
  endtask : rd_chk

  task automatic settle(input int c);
    repeat (c) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic watch();
    o1 = 0;
    e0 = 0;
    repeat (4) @(negedge clk);
    repeat (4000) begin
      @(negedge clk);
      if (sck === 1'b1) o1++;
      if (sck_oe === 1'b0) e0++;
    end
    @(posedge clk);
  endtask : watch

  task automatic finish_test();
    if (n_fail == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    req = '0;
    arst_n = 1'b0;
    {pin_hi, pin_lo, pwr, ckr, sel, cmp, ov} = 7'b1000000;
    dev_on = 1'b1;
    f_current_limit_sel = 2'h3;
    f_misc = 4'hA;
    f_ver = VER_A;
    n_fail = 0;
    n_checks = 0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd_chk("ctl rst", A_CTL, 8'h0B);
    rd_chk("msc rst", A_MSC, 8'h0A);
    rd_chk("ver rst", A_VER, VER_A);
    chk_pin("imm rst", 1'b1, imm);
    foreach (rows[i]) begin
      cmp <= rows[i].c;
      wr_reg(A_CTL, rows[i].d);
      rd_chk("ctl rd", A_CTL, rows[i].r);
      settle(0);
      chk_pin("sw on", rows[i].sw, sw_on);
      chk_pin("bypass", rows[i].by, byp);
      chk_reg("current_limit_sel", {6'h0, rows[i].r[1:0]}, {30'h0, current_limit_sel});
      @(posedge clk);
    end
    for (int m = 2; m < 4; m++) begin
      wr_reg(A_CTL, {4'h0, m[1:0], 2'h1});
      chk_pin("pwm clr", 1'b0, blk);
      ov <= 1'b1;
      @(posedge clk);
      ov <= 1'b0;
      settle(1);
      chk_pin("pwm blk", 1'b1, blk);
      chk_pin("bypass ov", 1'b0, byp);
      @(posedge clk);
      rd_chk("ctl ov", A_CTL, 8'h01);
    end
    wr_reg(A_CTL, 8'h05);
    ov <= 1'b1;
    rd_chk("ctl on ov", A_CTL, 8'h05);
    ov <= 1'b0;
    bus(1'b1, A_CTL, 8'h0F, 4'h0);
    rd_chk("ctl be", A_CTL, 8'h05);
    wr_reg(A_VER, 8'hFF);
    rd_chk("ver ro", A_VER, VER_A);
    wr_reg(A_BAD, 8'h55);
    rd_chk("unmapped", A_BAD, 8'h00);
    wr_reg(A_MSC, 8'hF2);
    rd_chk("msc rd", A_MSC, 8'h02);
    chk_pin("imm on", 1'b1, imm);
    wr_reg(A_MSC, 8'h08);
    chk_pin("imm off", 1'b0, imm);
    for (int k = 0; k < 4; k++) begin
      {pwr, ckr} <= k[1:0];
      settle(6);
      chk_pin("osc gated", |k[1:0], osc);
      @(posedge clk);
    end
    {pwr, ckr} <= 2'b00;
    wr_reg(A_MSC, 8'h00);
    settle(6);
    chk_pin("osc free", 1'b1, osc);
    @(posedge clk);
    dev_on <= 1'b0;
    settle(2);
    chk_pin("osc off", 1'b0, osc);
    @(posedge clk);
    dev_on <= 1'b1;
    wr_reg(A_MSC, 8'h04);
    for (int k = 1; k >= 0; k--) begin
      sel <= k[0];
      settle(8);
      chk_pin("sel fast", k[0], sel_eff);
      @(posedge clk);
    end
    wr_reg(A_MSC, 8'h00);
    sel <= 1'b1;
    settle(8);
    chk_pin("sel rise", 1'b1, sel_eff);
    @(posedge clk);
    sel <= 1'b0;
    settle(1800);
    chk_pin("sel held", 1'b1, sel_eff);
    n = 0;
    while (sel_eff !== 1'b0 && n < 3930) begin
      @(negedge clk);
      n++;
    end
    chk_pin("sel late", 1'b1, n < 3930);
    @(posedge clk);
    wr_reg(A_MSC, 8'h01);
    watch();
    chk_pin("od out", 1'b1, o1 == 0);
    chk_pin("od oe", 1'b1, e0 > 0 && e0 < 4000);
    wr_reg(A_MSC, 8'h00);
    watch();
    chk_pin("pp oe", 1'b1, e0 == 0);
    chk_pin("pp out", 1'b1, o1 > 0 && o1 < 4000);
    {pin_hi, pin_lo} <= 2'b01;
    f_current_limit_sel <= 2'h1;
    f_misc <= 4'h5;
    f_ver <= VER_B;
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd_chk("ctl rst2", A_CTL, 8'h05);
    rd_chk("msc rst2", A_MSC, 8'h05);
    rd_chk("ver rst2", A_VER, VER_B);
    finish_test();
  end

endmodule : tb_load_switch_and_misc_config_regs
`default_nettype wire
